// >>> src/embp_defs.svh
// Constants of the external memory bus port: widths, ranges and reset values.
// Operation
// - Address lines update in t0 per access.
// - Idle cycles hold the previous address value.
// - Reset, stop or no mastership: address and control outputs float.
// - Read data sampled at end of t2.
// - Write data driven t2 until next t0.
// - Data drivers off when idle and in reset.
// - Space select low for data, high program.
// - Idle cycle: select and direction high in t0.
// - Peripheral enable only for data FF00-FF7F.
// - Peripheral enable changes only in t0.
// - Direction high read, low write, in t0.
// - Write strobe low t1, high again t3.
// - Read strobe low t1, high again t3.
`ifndef EMBP_DEFS_SVH
`define EMBP_DEFS_SVH

`define EMBP_ADDR_W       16
`define EMBP_DATA_W       16
`define EMBP_PERIPH_LO    16'hff00
`define EMBP_PERIPH_HI    16'hff7f
`define EMBP_ADDR_RST     16'h0000
`define EMBP_DATA_RST     16'h0000
`define EMBP_RD_LATENCY   6
`define EMBP_RD_PIN_DEPTH 3

`endif

// >>> src/embp_pkg.sv
// Types shared by the external memory bus port.
package embp_pkg;

  typedef enum logic [1:0] {
    ph_t0,
    ph_t1,
    ph_t2,
    ph_t3
  } embp_phase_t;

endpackage

// >>> src/embp_phase_gen.sv
// Four phase sequencer that divides each bus cycle into t0 to t3.
`timescale 1ns/1ps
`default_nettype none

module embp_phase_gen (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Current phase.
  output var  embp_pkg::embp_phase_t phase_o
);

  embp_pkg::embp_phase_t phase_q;
  embp_pkg::embp_phase_t phase_d;

  always_comb begin
    unique case (phase_q)
      embp_pkg::ph_t0: phase_d = embp_pkg::ph_t1;
      embp_pkg::ph_t1: phase_d = embp_pkg::ph_t2;
      embp_pkg::ph_t2: phase_d = embp_pkg::ph_t3;
      embp_pkg::ph_t3: phase_d = embp_pkg::ph_t0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_q <= embp_pkg::ph_t0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;

endmodule

`default_nettype wire

// >>> src/embp_port.sv
// External asynchronous memory bus port with four phase bus cycles.
`timescale 1ns/1ps
`default_nettype none
`include "embp_defs.svh"

module embp_port #(
  parameter int ADDR_W = `EMBP_ADDR_W,
  parameter int DATA_W = `EMBP_DATA_W
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Core state.
  input  wire logic              bus_master_i,
  input  wire logic              stop_mode_i,
  // Access request from the core.
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic              req_data_space_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  // Read answer to the core.
  output logic                   rdata_valid_o,
  output logic [DATA_W-1:0]      rdata_o,
  // External address and data pins.
  output logic [ADDR_W-1:0]      ext_address_lines_o,
  output logic                   ext_address_lines_oe_o,
  input  wire logic [DATA_W-1:0] ext_data_lines_i,
  output logic [DATA_W-1:0]      ext_data_lines_o,
  output logic                   ext_data_lines_oe_o,
  // External bus control pins.
  output logic                   program_data_space_select_o,
  output logic                   peripheral_space_enable_n_o,
  output logic                   read_write_dir_o,
  output logic                   write_strobe_n_o,
  output logic                   read_strobe_n_o,
  output logic                   bus_ctrl_oe_o
);

  function automatic logic in_periph(input logic [ADDR_W-1:0] addr);
    in_periph = (addr >= ADDR_W'(`EMBP_PERIPH_LO)) && (addr <= ADDR_W'(`EMBP_PERIPH_HI));
  endfunction

  embp_pkg::embp_phase_t phase;

  logic              bus_en;
  logic              accept;
  logic              ready_q;
  logic              act_q;
  logic              wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              ps_q;
  logic              periph_en_n_q;
  logic              rw_q;
  logic              wr_n_q;
  logic              rd_n_q;
  logic              data_oe_q;
  logic              ctl_oe_q;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_s2_q;
  logic              rd_pend0_q;
  logic              rd_pend1_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;

  embp_phase_gen u_phase (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .phase_o (phase)
  );

  assign bus_en = bus_master_i && !stop_mode_i;
  assign accept = req_valid_i && ready_q;

  // Requests are offered in t3 so the access starts with the next t0.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (phase == embp_pkg::ph_t2) && bus_en;
    end
  end

  // Access attributes are latched when the request is taken.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      act_q   <= 1'b0;
      wr_q    <= 1'b0;
      wdata_q <= `EMBP_DATA_RST;
    end else if (phase == embp_pkg::ph_t3) begin
      act_q <= accept;
      if (accept) begin
        wr_q    <= req_write_i;
        wdata_q <= req_wdata_i;
      end
    end
  end

  // Address, space select, peripheral enable and direction move into t0.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_q        <= `EMBP_ADDR_RST;
      ps_q          <= 1'b1;
      periph_en_n_q <= 1'b1;
      rw_q          <= 1'b1;
    end else if (phase == embp_pkg::ph_t3) begin
      if (accept) begin
        addr_q        <= req_addr_i;
        ps_q          <= !req_data_space_i;
        periph_en_n_q <= !(req_data_space_i && in_periph(req_addr_i));
        rw_q          <= !req_write_i;
      end else begin
        ps_q          <= 1'b1;
        periph_en_n_q <= 1'b1;
        rw_q          <= 1'b1;
      end
    end
  end

  // Write and read strobes assert in t1 and release in t3.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else if (phase == embp_pkg::ph_t0) begin
      wr_n_q <= !(act_q && wr_q);
      rd_n_q <= !(act_q && !wr_q);
    end else if (phase == embp_pkg::ph_t2) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end
  end

  // Write data is driven from t2 until the next t0.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_oe_q <= 1'b0;
    end else if (phase == embp_pkg::ph_t1) begin
      data_oe_q <= act_q && wr_q;
    end else if (phase == embp_pkg::ph_t3) begin
      data_oe_q <= 1'b0;
    end
  end

  // Address and control drivers float in reset, stop or without mastership.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_oe_q <= 1'b0;
    end else begin
      ctl_oe_q <= bus_en;
    end
  end

  // Data pins pass two flip-flops before they are read.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      din_s1_q <= `EMBP_DATA_RST;
      din_s2_q <= `EMBP_DATA_RST;
    end else begin
      din_s1_q <= ext_data_lines_i;
      din_s2_q <= din_s1_q;
    end
  end

  // The pin value of t2 is taken from the synchroniser two cycles later.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_pend0_q <= 1'b0;
      rd_pend1_q <= 1'b0;
    end else begin
      rd_pend0_q <= (phase == embp_pkg::ph_t2) && act_q && !wr_q;
      rd_pend1_q <= rd_pend0_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= `EMBP_DATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_pend1_q;
      if (rd_pend1_q) begin
        rdata_q <= din_s2_q;
      end
    end
  end

  assign req_ready_o                 = ready_q;
  assign rdata_valid_o               = rvalid_q;
  assign rdata_o                     = rdata_q;
  assign ext_address_lines_o         = addr_q;
  assign ext_address_lines_oe_o      = ctl_oe_q;
  assign ext_data_lines_o            = wdata_q;
  assign ext_data_lines_oe_o         = data_oe_q;
  assign program_data_space_select_o = ps_q;
  assign peripheral_space_enable_n_o = periph_en_n_q;
  assign read_write_dir_o            = rw_q;
  assign write_strobe_n_o            = wr_n_q;
  assign read_strobe_n_o             = rd_n_q;
  assign bus_ctrl_oe_o               = ctl_oe_q;

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rst_n_i);

  property p_addr_t0;
    $changed(ext_address_lines_o) |-> (phase == embp_pkg::ph_t0);
  endproperty
  a_addr_t0: assert property (p_addr_t0)
    else $error("Address lines changed outside t0.");

  property p_addr_load;
    accept |=> (ext_address_lines_o == $past(req_addr_i));
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("Address lines do not carry the accepted address in t0.");

  property p_addr_hold;
    ((phase == embp_pkg::ph_t3) && !accept) |=> $stable(ext_address_lines_o)[*4];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("Address lines moved during an idle bus cycle.");

  property p_float;
    !bus_en |=> (!bus_ctrl_oe_o && !ext_address_lines_oe_o);
  endproperty
  a_float: assert property (p_float)
    else $error("Address or control drivers on without bus ownership.");

  property p_rd_capture;
    (accept && !req_write_i) |-> ##6 (rdata_valid_o
      && (rdata_o == $past(ext_data_lines_i, 3)));
  endproperty
  a_rd_capture: assert property (p_rd_capture)
    else $error("Read data was not the pin value at the end of t2.");

  property p_wr_drive;
    (accept && req_write_i) |-> ##1 !ext_data_lines_oe_o[*2] ##1 ext_data_lines_oe_o[*2]
      ##1 !ext_data_lines_oe_o;
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("Write data not driven exactly from t2 to the next t0.");

  property p_data_idle;
    ((phase == embp_pkg::ph_t1) && !(act_q && wr_q)) |-> ##1 !ext_data_lines_oe_o[*2];
  endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("Data drivers on with no write in progress.");

  property p_space_dir;
    ((phase == embp_pkg::ph_t3) && accept) |=>
      (program_data_space_select_o == !$past(req_data_space_i))
      && (read_write_dir_o == !$past(req_write_i));
  endproperty
  a_space_dir: assert property (p_space_dir)
    else $error("Space select or direction wrong for the access.");

  property p_idle_high;
    ((phase == embp_pkg::ph_t3) && !accept) |=>
      (program_data_space_select_o && read_write_dir_o && peripheral_space_enable_n_o);
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("Select or direction not high in an idle cycle.");

  property p_periph;
    accept |=> (peripheral_space_enable_n_o
      == !($past(req_data_space_i) && in_periph($past(req_addr_i))));
  endproperty
  a_periph: assert property (p_periph)
    else $error("Peripheral enable does not match the address range.");

  property p_periph_t0;
    $changed(peripheral_space_enable_n_o) |-> (phase == embp_pkg::ph_t0);
  endproperty
  a_periph_t0: assert property (p_periph_t0)
    else $error("Peripheral enable changed outside t0.");

  property p_wr_strobe;
    (accept && req_write_i) |-> ##1 write_strobe_n_o ##1 !write_strobe_n_o[*2]
      ##1 write_strobe_n_o;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("Write strobe not low from t1 to t3.");

  property p_rd_strobe;
    (accept && !req_write_i) |-> ##1 read_strobe_n_o ##1 !read_strobe_n_o[*2]
      ##1 read_strobe_n_o && write_strobe_n_o;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("Read strobe not low from t1 to t3.");

  c_read: cover property (accept && !req_write_i ##6 rdata_valid_o);
  c_write: cover property (accept && req_write_i ##3 ext_data_lines_oe_o);
  c_periph: cover property (accept && req_data_space_i && in_periph(req_addr_i));
  c_b2b_wr: cover property (accept && req_write_i ##4 accept && req_write_i);

endmodule

`default_nettype wire

// >>> test/embp_sram_model.sv
// Behavioural static memory on the far side of the external bus.
`timescale 1ns/1ps
`default_nettype none

module embp_sram_model (
  // Clock.
  input  wire logic        clk_i,
  // Pins driven by the port.
  input  wire logic [15:0] addr_i,
  input  wire logic        ctrl_oe_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] dut_data_i,
  input  wire logic        dut_oe_i,
  // Answer speed.
  input  wire logic        slow_i,
  // Resolved data wire.
  output logic [15:0]      bus_o
);
  logic [15:0] mem_q [256];
  logic [15:0] last_q = 16'h0000;
  logic        rd_n_q = 1'b1;
  logic        wr_n_q = 1'b1;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = 16'hc3a0 ^ 16'(i);
    end
  end

  // A slow answer shows changing junk in the first strobe cycle; a floating wire never holds.
  always_comb begin
    if (dut_oe_i) begin
      bus_o = dut_data_i;
    end else if (ctrl_oe_i && !rd_n_i && !(slow_i && rd_n_q)) begin
      bus_o = mem_q[addr_i[7:0]];
    end else begin
      bus_o = ~last_q;
    end
  end

  always @(posedge clk_i) begin
    last_q <= bus_o;
    rd_n_q <= rd_n_i;
    wr_n_q <= wr_n_i;
    if (ctrl_oe_i && !wr_n_q && wr_n_i) begin
      mem_q[addr_i[7:0]] <= bus_o;
    end
  end
endmodule

`default_nettype wire

// >>> test/embp_port_bench.sv
// Self-checking bench for the external memory bus port.
`timescale 1ns/1ps
`default_nettype none

module embp_port_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        master = 1'b1;
  logic        stop = 1'b0;
  logic        valid = 1'b0;
  logic        wr = 1'b0;
  logic        ds = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] pin_d, rdata, a_o, d_o;
  logic        rdy, rvld, a_oe, d_oe, sel, pen_n, dir, wr_n, rd_n, c_oe;
  int          err_total = 0;
  int          samples_checked = 0;
  int          seed = 32'hd218;
  logic [15:0] shadow [256];
  logic [15:0] exp_q [$];
  logic [15:0] tbl [4] = '{16'hff00, 16'hff7f, 16'hff80, 16'hfeff};

  always #5 clk = ~clk;

  embp_port u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .bus_master_i(master), .stop_mode_i(stop),
    .req_valid_i(valid), .req_write_i(wr), .req_data_space_i(ds), .req_addr_i(addr),
    .req_wdata_i(wdata), .req_ready_o(rdy), .rdata_valid_o(rvld), .rdata_o(rdata),
    .ext_address_lines_o(a_o), .ext_address_lines_oe_o(a_oe), .ext_data_lines_i(pin_d),
    .ext_data_lines_o(d_o), .ext_data_lines_oe_o(d_oe), .program_data_space_select_o(sel),
    .peripheral_space_enable_n_o(pen_n), .read_write_dir_o(dir), .write_strobe_n_o(wr_n),
    .read_strobe_n_o(rd_n), .bus_ctrl_oe_o(c_oe));

  embp_sram_model u_mem (
    .clk_i(clk), .addr_i(a_o), .ctrl_oe_i(c_oe), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .dut_data_i(d_o), .dut_oe_i(d_oe), .slow_i(slow), .bus_o(pin_d));

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic access(input logic w, input logic d, input logic [15:0] a,
                        input logic [15:0] dat);
    int n;
    n = 0;
    valid = 1'b1;
    wr = w;
    ds = d;
    addr = a;
    wdata = dat;
    while (rdy !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("ready", 16'(rdy), 16'h0001);
    if (w) shadow[a[7:0]] = dat;
    else exp_q.push_back(shadow[a[7:0]]);
    @(negedge clk);
    chk("addr", a_o, a);
    chk("sel", 16'(sel), 16'(!d));
    chk("pen", 16'(pen_n), 16'(!(d && a >= 16'hff00 && a <= 16'hff7f)));
    chk("dir", 16'(dir), 16'(!w));
    @(negedge clk);
    chk("strobe", 16'(w ? wr_n : rd_n), 16'h0000);
    @(negedge clk);
    if (w) begin
      chk("d_oe", 16'(d_oe), 16'h0001);
      chk("d_out", d_o, dat);
    end
  endtask

  task automatic idle(input logic [15:0] a);
    valid = 1'b0;
    repeat (8) @(negedge clk);
    chk("idle_addr", a_o, a);
    chk("idle_sel_dir", 16'({sel, dir, pen_n}), 16'h0007);
    chk("idle_d_oe", 16'(d_oe), 16'h0000);
  endtask

  task automatic refused();
    repeat (4) @(negedge clk);
    chk("float", 16'({a_oe, c_oe, d_oe}), 16'h0000);
    valid = 1'b1;
    repeat (8) begin
      @(negedge clk);
      chk("ready_off", 16'(rdy), 16'h0000);
    end
    valid = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (rvld === 1'b1) begin
      if (exp_q.size() == 0) chk("rdata_extra", 16'h0001, 16'h0000);
      else chk("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    logic [15:0] ra, rd;
    for (int i = 0; i < 256; i++) shadow[i] = 16'hc3a0 ^ 16'(i);
    repeat (16) @(negedge clk);
    chk("rst_oe", 16'({a_oe, c_oe, d_oe}), 16'h0000);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      slow = i[1];
      access(1'b0, i[0], tbl[i[2:1]], 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      ra = 16'($random(seed));
      rd = 16'($random(seed));
      access(1'b1, ra[0], ra, rd);
      access(1'b0, ra[0], ra, 16'h0000);
    end
    idle(ra);
    stop = 1'b1;
    refused();
    stop = 1'b0;
    master = 1'b0;
    refused();
    master = 1'b1;
    idle(ra);
    chk("drained", 16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule

`default_nettype wire
